// ### dmct_pins.sv
`timescale 1ns/1ps
`default_nettype none
// far side: edge-detection pulses and oscillator levels, all idle low
module dmct_pins (
   input wire logic hclk,
   output logic [5:0] ev,
   output logic slow_osc,
   output logic main_osc
);
   initial begin
      ev = 6'h00;
      slow_osc = 1'b0;
      main_osc = 1'b0;
   end

   // one-cycle detection pulse; the gap covers the two-flop sync latency
   task automatic pulse(input int n);
      @(posedge hclk);
      ev[n] <= 1'b1;
      @(posedge hclk);
      ev <= 6'h00;
      repeat (4) @(posedge hclk);
   endtask

   // kind 0 slow oscillator, 1 main oscillator, 2 to 7 event pin kind-2
   task automatic tick(input int k);
      if (k >= 2) begin
         pulse(k - 2);
      end else begin
         @(posedge hclk);
         {main_osc, slow_osc} <= 2'(1 << k);
         repeat (3) @(posedge hclk);
         {main_osc, slow_osc} <= 2'h0;
         repeat (4) @(posedge hclk);
      end
   endtask
endmodule
`default_nettype wire

// ### dmct_pkg.sv
package dmct_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [15:0] IDX_LOW_MATCH = 16'h7e18;
   localparam logic [15:0] IDX_HIGH_MATCH = 16'h7e19;
   localparam logic [15:0] IDX_LOW_COUNT = 16'h7f1a;
   localparam logic [15:0] IDX_HIGH_COUNT = 16'h7f1b;
   localparam logic [15:0] IDX_RUN_CTRL = 16'h7f1c;
   localparam logic [15:0] IDX_CAP_CTRL = 16'h7f1d;
   localparam logic [15:0] IDX_CLK_CTRL = 16'h7f1e;

   localparam logic [31:0] BA_LOW_MATCH = {14'h0000, IDX_LOW_MATCH, 2'h0};
   localparam logic [31:0] BA_HIGH_MATCH = {14'h0000, IDX_HIGH_MATCH, 2'h0};
   localparam logic [31:0] BA_LOW_COUNT = {14'h0000, IDX_LOW_COUNT, 2'h0};
   localparam logic [31:0] BA_HIGH_COUNT = {14'h0000, IDX_HIGH_COUNT, 2'h0};
   localparam logic [31:0] BA_RUN_CTRL = {14'h0000, IDX_RUN_CTRL, 2'h0};
   localparam logic [31:0] BA_CAP_CTRL = {14'h0000, IDX_CAP_CTRL, 2'h0};
   localparam logic [31:0] BA_CLK_CTRL = {14'h0000, IDX_CLK_CTRL, 2'h0};

   // run_control_reg fields
   localparam int RC_HIGH_RUN = 7;
   localparam int RC_HIGH_FLAG = 6;
   localparam int RC_HIGH_IE = 5;
   localparam int RC_SPLIT = 4;
   localparam int RC_CAP_RD = 3;
   localparam int RC_LOW_RUN = 2;
   localparam int RC_LOW_FLAG = 1;
   localparam int RC_LOW_IE = 0;

   // capture_control_reg fields
   localparam int CC_SRC_LSB = 3;
   localparam int CC_HIGH_FLAG = 2;
   localparam int CC_LOW_FLAG = 1;
   localparam int CC_IE = 0;
   localparam logic [7:0] CC_WR_MASK = 8'h1f;

   // clock_control_reg fields
   localparam int KC_SRC_LSB = 6;
   localparam int KC_EVSEL = 5;
   localparam int KC_LIMIT_LSB = 0;
   localparam logic [7:0] KC_WR_MASK = 8'hef;

   // reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_COUNTER = 8'h00;
   localparam logic [3:0] RST_PRESC = 4'h0;

   typedef enum logic [1:0] {
      CKS_SYS = 2'h0,
      CKS_EVENT = 2'h1,
      CKS_SLOW = 2'h2,
      CKS_MAIN = 2'h3
   } dmct_cks_e;

endpackage

// ### dmct_timer.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R1) prescaler matches divider_limit, then clears; clears when stopped
// (R2) prescaler runs on low run, or split high run
// (R3) clock_source_sel picks prescaler clock source
// (R4) low counter runs exactly on low run bit
// (R5) high counter: low run, or high_run_enable when split
// (R6) low counts prescaler match; split 01 counts pin 2
// (R7) high counts low overflow, or prescaler when split
// (R8) counter match clears it; 16-bit needs both bytes
// (R9) low buffer tracks when stopped, loads at zero
// (R10) high buffer tracks when stopped, loads at zero
// (R11) software rewrites match value once per period
// (R12) capture_source_sel picks low capture event pin
// (R13) high capture pin: shared, or own split table
// (R14) 16-bit capture copies both bytes together
// (R15) match flag with enable raises timer request
// (R16) capture flag with enable raises capture request
// (R17) counters are read-only, reset to zero
// (R18) split_mode selects one 16-bit or two 8-bit
// (R19) match flags set on period, cleared by zero
// (R20) capture_read_sel swaps counter reads to captures
// (R21) capture flags set on update, cleared by zero
// (R22) event pins synchronised before use
module dmct_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic slow_crystal_clock,
   input wire logic main_osc_clock,
   input wire logic event_pin_0,
   input wire logic event_pin_1,
   input wire logic event_pin_2,
   input wire logic event_pin_3,
   input wire logic event_pin_4,
   input wire logic event_pin_5,
   output logic timer_irq,
   output logic capture_irq
);

   logic [7:0] low_match_value;
   logic [7:0] high_match_value;
   logic [7:0] run_control_reg;
   logic [7:0] capture_control_reg;
   logic [7:0] clock_control_reg;
   logic [7:0] low_counter;
   logic [7:0] high_counter;
   logic [7:0] low_capture_reg;
   logic [7:0] high_capture_reg;
   logic [7:0] low_buf;
   logic [7:0] high_buf;
   logic [3:0] presc_cnt;
   logic [5:0] ev_s1;
   logic [5:0] ev_s2;
   logic [1:0] osc_s1;
   logic [1:0] osc_s2;
   logic [1:0] osc_s3;
   logic [31:0] dph_addr;
   logic dph_wr;
   logic rd_wait;

   // ---- bus slave: transfer accept and data-phase write decode ----
   wire logic accept = hsel & htrans[1] & hready;
   wire logic [7:0] wdat = hwdata[7:0];
   wire logic wr_low_match = dph_wr & (dph_addr == dmct_pkg::BA_LOW_MATCH);
   wire logic wr_high_match = dph_wr & (dph_addr == dmct_pkg::BA_HIGH_MATCH);
   wire logic wr_run = dph_wr & (dph_addr == dmct_pkg::BA_RUN_CTRL);
   wire logic wr_cap = dph_wr & (dph_addr == dmct_pkg::BA_CAP_CTRL);
   wire logic wr_clk = dph_wr & (dph_addr == dmct_pkg::BA_CLK_CTRL);

   // ---- control fields ----
   wire logic high_run_enable = run_control_reg[dmct_pkg::RC_HIGH_RUN];
   wire logic high_match_flag = run_control_reg[dmct_pkg::RC_HIGH_FLAG];
   wire logic high_irq_enable = run_control_reg[dmct_pkg::RC_HIGH_IE];
   wire logic split_mode = run_control_reg[dmct_pkg::RC_SPLIT];
   wire logic capture_read_sel = run_control_reg[dmct_pkg::RC_CAP_RD];
   wire logic low_run = run_control_reg[dmct_pkg::RC_LOW_RUN];
   wire logic low_match_flag = run_control_reg[dmct_pkg::RC_LOW_FLAG];
   wire logic low_irq_enable = run_control_reg[dmct_pkg::RC_LOW_IE];
   wire logic [1:0] capture_source_sel = capture_control_reg[dmct_pkg::CC_SRC_LSB +: 2];
   wire logic capture_high_flag = capture_control_reg[dmct_pkg::CC_HIGH_FLAG];
   wire logic capture_low_flag = capture_control_reg[dmct_pkg::CC_LOW_FLAG];
   wire logic capture_irq_enable = capture_control_reg[dmct_pkg::CC_IE];
   wire logic [1:0] clock_source_sel = clock_control_reg[dmct_pkg::KC_SRC_LSB +: 2];
   wire logic event_pin_sel = clock_control_reg[dmct_pkg::KC_EVSEL];
   wire logic [3:0] divider_limit = clock_control_reg[dmct_pkg::KC_LIMIT_LSB +: 4];

   // ---- synchronised pins; events read at the second stage, oscillator edges from the second and third ----
   wire logic [5:0] ev = ev_s2;
   wire logic slow_edge = osc_s2[0] & ~osc_s3[0];
   wire logic main_edge = osc_s2[1] & ~osc_s3[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_s1 <= 6'h00;
         ev_s2 <= 6'h00;
         osc_s1 <= 2'h0;
         osc_s2 <= 2'h0;
         osc_s3 <= 2'h0;
      end else if (clk_en) begin
         ev_s1 <= {event_pin_5, event_pin_4, event_pin_3, event_pin_2, event_pin_1, event_pin_0}; // R22
         ev_s2 <= ev_s1; // R22
         osc_s1 <= {main_osc_clock, slow_crystal_clock};
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end

   // ---- prescaler ----
   wire logic presc_run = low_run | (split_mode & high_run_enable); // R2
   // split mode without the pin-3 choice falls back to the system clock
   wire logic event_tick = event_pin_sel ? ev[3] : (split_mode ? 1'h1 : ev[2]);
   wire logic presc_tick = (clock_source_sel == dmct_pkg::CKS_SYS) ? 1'h1 : // R3
      (clock_source_sel == dmct_pkg::CKS_EVENT) ? event_tick :
      (clock_source_sel == dmct_pkg::CKS_SLOW) ? slow_edge : main_edge;
   wire logic presc_hit = presc_run & presc_tick & (presc_cnt == divider_limit); // R1
   wire logic [3:0] next_presc = (!presc_run || presc_hit) ? dmct_pkg::RST_PRESC : // R1
      (presc_tick ? presc_cnt + 4'h1 : presc_cnt);

   // ---- counter clocking and matches ----
   wire logic pin_direct = split_mode & (clock_source_sel == dmct_pkg::CKS_EVENT);
   wire logic lo_tick = low_run & (pin_direct ? ev[2] : presc_hit); // R4 R6
   wire logic hi_run = split_mode ? high_run_enable : low_run; // R5 R18
   wire logic m16 = ~split_mode & lo_tick & ({high_counter, low_counter} == {high_buf, low_buf}); // R8
   wire logic lo_carry = lo_tick & (low_counter == 8'hff) & ~m16;
   wire logic hi_tick = hi_run & (split_mode ? presc_hit : lo_carry); // R7
   wire logic lo_match = split_mode ? (lo_tick & (low_counter == low_buf)) : m16; // R8
   wire logic hi_match = split_mode & hi_tick & (high_counter == high_buf); // R8

   // a stopped counter sits at zero, a matching one wraps to zero
   wire logic [7:0] next_low = (!low_run || lo_match) ? dmct_pkg::RST_COUNTER :
      (lo_tick ? low_counter + 8'h01 : low_counter);
   wire logic [7:0] next_high = (!hi_run || hi_match || m16) ? dmct_pkg::RST_COUNTER :
      (hi_tick ? high_counter + 8'h01 : high_counter);

   // buffers load only at zero so a period is never cut short mid-count
   wire logic [7:0] next_low_buf = (!low_run || low_counter == 8'h00) ? low_match_value : low_buf; // R9
   wire logic [7:0] next_high_buf = (!hi_run || high_counter == 8'h00) ? high_match_value : high_buf; // R10

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_cnt <= dmct_pkg::RST_PRESC;
         low_counter <= dmct_pkg::RST_COUNTER; // R17
         high_counter <= dmct_pkg::RST_COUNTER; // R17
         low_buf <= dmct_pkg::RST_REG;
         high_buf <= dmct_pkg::RST_REG;
      end else if (clk_en) begin
         presc_cnt <= next_presc;
         low_counter <= next_low;
         high_counter <= next_high;
         low_buf <= next_low_buf;
         high_buf <= next_high_buf;
      end
   end

   // ---- capture ----
   wire logic cap_lo_evt = (capture_source_sel == 2'h0) ? ev[0] : // R12
      (capture_source_sel == 2'h1) ? ev[2] :
      (capture_source_sel == 2'h2) ? ev[4] : ev[5];
   wire logic cap_hi_own = (capture_source_sel == 2'h0) ? ev[1] : // R13
      (capture_source_sel == 2'h1) ? ev[3] :
      (capture_source_sel == 2'h2) ? ev[5] : ev[4];
   wire logic cap_hi_evt = split_mode ? cap_hi_own : cap_lo_evt; // R13 R14

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_capture_reg <= dmct_pkg::RST_COUNTER;
         high_capture_reg <= dmct_pkg::RST_COUNTER;
      end else if (clk_en) begin
         if (cap_lo_evt) begin
            low_capture_reg <= low_counter; // R12 R14
         end
         if (cap_hi_evt) begin
            high_capture_reg <= high_counter; // R13 R14
         end
      end
   end

   // ---- flags: hardware set wins over a same-cycle software clear ----
   wire logic cap_low_set = cap_lo_evt; // R21
   wire logic cap_high_set = split_mode & cap_hi_evt; // R21
   wire logic [7:0] run_set = {1'h0, hi_match, 4'h0, lo_match, 1'h0}; // R19
   wire logic [7:0] next_run = wr_run ?
      {wdat[7], (wdat[6] & high_match_flag) | hi_match, wdat[5:2],
       (wdat[1] & low_match_flag) | lo_match, wdat[0]} : run_control_reg | run_set; // R19
   wire logic [7:0] cap_set = {5'h00, cap_high_set, cap_low_set, 1'h0};
   wire logic [7:0] cap_wr = wdat & dmct_pkg::CC_WR_MASK;
   wire logic [7:0] next_cap = wr_cap ?
      {cap_wr[7:3], (cap_wr[2] & capture_high_flag) | cap_high_set,
       (cap_wr[1] & capture_low_flag) | cap_low_set, cap_wr[0]} : capture_control_reg | cap_set; // R21

   // writes to counter addresses fall through and change nothing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_match_value <= dmct_pkg::RST_REG;
         high_match_value <= dmct_pkg::RST_REG;
         run_control_reg <= dmct_pkg::RST_REG;
         capture_control_reg <= dmct_pkg::RST_REG;
         clock_control_reg <= dmct_pkg::RST_REG;
      end else if (clk_en) begin
         if (wr_low_match) begin
            low_match_value <= wdat;
         end
         if (wr_high_match) begin
            high_match_value <= wdat;
         end
         if (wr_clk) begin
            clock_control_reg <= wdat & dmct_pkg::KC_WR_MASK;
         end
         run_control_reg <= next_run;
         capture_control_reg <= next_cap;
      end
   end

   // ---- interrupt requests, levels from the sticky flags ----
   assign timer_irq = (low_match_flag & low_irq_enable) | (high_match_flag & high_irq_enable); // R15
   assign capture_irq = capture_irq_enable & (capture_low_flag | capture_high_flag); // R16

   // ---- bus slave: data phase ----
   // reads take one wait state so a read right after a write sees the new value
   wire logic [7:0] rd_low = capture_read_sel ? low_capture_reg : low_counter; // R20
   wire logic [7:0] rd_high = capture_read_sel ? high_capture_reg : high_counter; // R20
   wire logic [7:0] rd_mux = (dph_addr == dmct_pkg::BA_LOW_MATCH) ? low_match_value :
      (dph_addr == dmct_pkg::BA_HIGH_MATCH) ? high_match_value :
      (dph_addr == dmct_pkg::BA_LOW_COUNT) ? rd_low :
      (dph_addr == dmct_pkg::BA_HIGH_COUNT) ? rd_high :
      (dph_addr == dmct_pkg::BA_RUN_CTRL) ? run_control_reg :
      (dph_addr == dmct_pkg::BA_CAP_CTRL) ? capture_control_reg :
      (dph_addr == dmct_pkg::BA_CLK_CTRL) ? clock_control_reg : 8'h00;

   assign hreadyout = clk_en & ~rd_wait;
   assign hresp = 1'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_addr <= 32'h0000_0000;
         dph_wr <= 1'h0;
         rd_wait <= 1'h0;
         hrdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (rd_wait) begin
            hrdata <= {24'h000000, rd_mux};
            rd_wait <= 1'h0;
         end else if (hready) begin
            dph_wr <= accept & hwrite;
            rd_wait <= accept & ~hwrite;
            if (accept) begin
               dph_addr <= haddr;
            end
         end
      end
   end

   // ---- checks ----
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_presc_wrap: assert property (clk_en && presc_hit |=> presc_cnt == 4'h0) // R1
      else $error("prescaler did not clear on match");
   a_presc_stop: assert property (clk_en && !presc_run |=> presc_cnt == 4'h0) // R2
      else $error("stopped prescaler not at zero");
   a_sys_clock: assert property (clk_en && presc_run && clock_source_sel == 2'h0 && !presc_hit // R3
      |=> presc_cnt == $past(presc_cnt) + 4'h1)
      else $error("system clock source did not advance prescaler");
   a_low_stopped: assert property (clk_en && !low_run |=> low_counter == 8'h00) // R4
      else $error("stopped low counter not zero");
   a_high_split: assert property (clk_en && split_mode && !high_run_enable |=> high_counter == 8'h00) // R5
      else $error("split high counter ran without its enable");
   a_low_count: assert property (clk_en && lo_tick && !lo_match // R6
      |=> low_counter == $past(low_counter) + 8'h01)
      else $error("low counter missed a tick");
   a_high_carry: assert property (clk_en && !split_mode && lo_carry // R7
      |=> high_counter == $past(high_counter) + 8'h01 && low_counter == 8'h00)
      else $error("high counter missed low overflow");
   a_match_clear: assert property (clk_en && m16 |=> low_counter == 8'h00 && high_counter == 8'h00) // R8
      else $error("16-bit match did not clear counters");
   a_low_buffer: assert property (clk_en && !low_run |=> low_buf == $past(low_match_value)) // R9
      else $error("stopped low buffer not tracking");
   a_high_buffer: assert property (clk_en && !hi_run |=> high_buf == $past(high_match_value)) // R10
      else $error("stopped high buffer not tracking");
   a_coherent_cap: assert property (clk_en && !split_mode && cap_lo_evt // R14
      |=> low_capture_reg == $past(low_counter) && high_capture_reg == $past(high_counter) && capture_low_flag)
      else $error("16-bit capture not coherent");
   a_match_flag: assert property (clk_en && lo_match |=> low_match_flag && (!low_irq_enable || timer_irq)) // R19
      else $error("low match flag or request missing");
   a_cap_request: assert property (capture_irq_enable && capture_low_flag |-> capture_irq) // R16
      else $error("capture request missing");

   // further guards on capture, requests, counters, flags, buffers, pin sync, read select and the bus wait state
   a_cap_low: assert property (clk_en && cap_lo_evt |=> low_capture_reg == $past(low_counter)) // R12
      else $error("low capture missed its event");
   a_cap_high: assert property (clk_en && cap_hi_evt |=> high_capture_reg == $past(high_counter)) // R13
      else $error("high capture missed its event");
   a_split_hflag: assert property (clk_en && split_mode && cap_hi_evt |=> capture_high_flag) // R21
      else $error("split high capture flag not set");
   a_high_req: assert property (high_match_flag && high_irq_enable |-> timer_irq) // R15
      else $error("high timer request missing");
   a_cap_hreq: assert property (capture_irq_enable && capture_high_flag |-> capture_irq) // R16
      else $error("high capture request missing");
   a_low_hold: assert property (clk_en && low_run && !lo_tick |=> low_counter == $past(low_counter)) // R17
      else $error("low counter moved without a tick");
   a_read_cap: assert property (capture_read_sel && dph_addr == dmct_pkg::BA_LOW_COUNT |-> rd_mux == low_capture_reg) // R20
      else $error("capture read select ignored");
   a_high_flag: assert property (clk_en && hi_match |=> high_match_flag) // R19
      else $error("high match flag not set");
   a_pin_sync: assert property (clk_en && event_pin_0 ##1 clk_en |=> ev[0]) // R22
      else $error("event pin not through two stages");
   a_high_16: assert property (clk_en && !split_mode && !low_run |=> high_counter == 8'h00) // R5
      else $error("16-bit high counter ran while stopped");
   a_low_buf_hold: assert property (clk_en && low_run && low_counter != 8'h00 |=> low_buf == $past(low_buf)) // R9
      else $error("low buffer reloaded mid-period");
   a_high_buf_hold: assert property (clk_en && hi_run && high_counter != 8'h00 |=> high_buf == $past(high_buf)) // R10
      else $error("high buffer reloaded mid-period");
   a_split_tick: assert property (clk_en && split_mode && hi_tick && !hi_match // R7
      |=> high_counter == $past(high_counter) + 8'h01)
      else $error("split high counter missed a tick");
   a_read_wait: assert property (clk_en && accept && !hwrite && !rd_wait |=> !hreadyout) // R20
      else $error("read data phase lacks its wait state");

endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic hreadyout, hresp, timer_irq, capture_irq, slow_osc, main_osc;
   logic [31:0] hrdata;
   logic [5:0] ev;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int i;
   logic [15:0] all_t[8] = '{16'h7e18, 16'h7e19, 16'h7f1a, 16'h7f1b, 16'h7f1c, 16'h7f1d, 16'h7f1e, 16'h7f1f};
   logic [7:0] kc_t[5] = '{8'h80, 8'hc0, 8'h40, 8'h60, 8'h40};
   logic [7:0] rc_t[5] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h14};
   int k_t[5] = '{0, 1, 4, 5, 4};
   int lo_p[4] = '{0, 2, 4, 5};
   int hi_p[4] = '{1, 3, 5, 4};

   dmct_timer DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .slow_crystal_clock(slow_osc),
      .main_osc_clock(main_osc), .event_pin_0(ev[0]), .event_pin_1(ev[1]), .event_pin_2(ev[2]),
      .event_pin_3(ev[3]), .event_pin_4(ev[4]), .event_pin_5(ev[5]), .timer_irq(timer_irq),
      .capture_irq(capture_irq));
   dmct_pins pins (.hclk(hclk), .ev(ev), .slow_osc(slow_osc), .main_osc(main_osc));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) cyc <= cyc + 1;

   // single word transfer; hready and read data are sampled at the rising edge itself
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {14'h0000, idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] rd;
      bus(1'b1, idx, d, rd);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] rd;
      bus(1'b0, idx, 8'h00, rd);
      chk({8'h00, rd}, {8'h00, exp});
      chk({15'h0000, hresp}, 16'h0000);
   endtask
   // bounded wait for the timer request, stamped with the cycle count
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      do @(negedge hclk); while (timer_irq !== 1'b1 && ++n < 2000);
      if (n >= 2000) begin
         n_errors++;
         $display("[FAIL] %0t timer request never came", $time);
      end
      t = cyc;
      @(posedge hclk);
   endtask
   // three periods: flags cleared by writing zero, new match value mid-period
   task automatic per(input logic [7:0] rc, lm, hm, pr, nlm, input logic [15:0] e1, e2);
      int t1, t2, t3;
      wr(dmct_pkg::IDX_CLK_CTRL, pr);
      wr(dmct_pkg::IDX_LOW_MATCH, lm);
      wr(dmct_pkg::IDX_HIGH_MATCH, hm);
      wr(dmct_pkg::IDX_RUN_CTRL, rc);
      wait_irq(t1);
      wr(dmct_pkg::IDX_RUN_CTRL, rc);
      wr(dmct_pkg::IDX_LOW_MATCH, nlm);
      wait_irq(t2);
      wr(dmct_pkg::IDX_RUN_CTRL, rc);
      wait_irq(t3);
      chk(16'(t2 - t1), e1);
      chk(16'(t3 - t2), e2);
      if (!rc[2]) rchk(dmct_pkg::IDX_LOW_COUNT, 8'h00);
      wr(dmct_pkg::IDX_RUN_CTRL, 8'h00);
   endtask
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog far beyond the roughly two thousand cycles the sequence needs
   initial begin
      #2000000;
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values, unmapped slot last
      for (i = 0; i < 8; i++) rchk(all_t[i], 8'h00);
      wr(dmct_pkg::IDX_LOW_MATCH, 8'ha5);
      rchk(dmct_pkg::IDX_LOW_MATCH, 8'ha5);
      wr(dmct_pkg::IDX_HIGH_MATCH, 8'h5a);
      rchk(dmct_pkg::IDX_HIGH_MATCH, 8'h5a);
      wr(dmct_pkg::IDX_CAP_CTRL, 8'hff);
      rchk(dmct_pkg::IDX_CAP_CTRL, 8'h19);
      wr(dmct_pkg::IDX_CLK_CTRL, 8'hff);
      rchk(dmct_pkg::IDX_CLK_CTRL, 8'hef);
      wr(dmct_pkg::IDX_CAP_CTRL, 8'h00);
      // periods: 16-bit, split low, split high alone
      per(8'h05, 8'h03, 8'h01, 8'h01, 8'h03, 16'd520, 16'd520);
      per(8'h15, 8'h09, 8'h00, 8'h02, 8'h13, 16'd30, 16'd60);
      per(8'hb0, 8'h00, 8'h04, 8'h03, 8'h00, 16'd20, 16'd20);
      // clock sources: three wanted ticks, one from the wrong source
      wr(dmct_pkg::IDX_LOW_MATCH, 8'hff);
      for (i = 0; i < 5; i++) begin
         wr(dmct_pkg::IDX_RUN_CTRL, 8'h00);
         wr(dmct_pkg::IDX_CLK_CTRL, kc_t[i]);
         wr(dmct_pkg::IDX_RUN_CTRL, rc_t[i]);
         repeat (3) pins.tick(k_t[i]);
         pins.tick(k_t[i] ^ 1);
         rchk(dmct_pkg::IDX_LOW_COUNT, 8'h03);
      end
      wr(dmct_pkg::IDX_LOW_COUNT, 8'h55);
      rchk(dmct_pkg::IDX_LOW_COUNT, 8'h03);
      // capture pin tables; enabled then masked capture request
      for (i = 0; i < 4; i++) begin
         wr(dmct_pkg::IDX_CAP_CTRL, 8'(i << 3) | 8'h01);
         pins.pulse(lo_p[i]);
         rchk(dmct_pkg::IDX_CAP_CTRL, 8'(i << 3) | 8'h03);
         chk(16'(capture_irq), 16'h0001);
         wr(dmct_pkg::IDX_CAP_CTRL, 8'(i << 3));
         pins.pulse(hi_p[i]);
         rchk(dmct_pkg::IDX_CAP_CTRL, 8'(i << 3) | 8'h04);
         chk(16'(capture_irq), 16'h0000);
      end
      pins.pulse(2);
      wr(dmct_pkg::IDX_RUN_CTRL, 8'h1c);
      rchk(dmct_pkg::IDX_LOW_COUNT, 8'h04);
      rchk(dmct_pkg::IDX_HIGH_COUNT, 8'h00);
      wr(dmct_pkg::IDX_RUN_CTRL, 8'h14);
      rchk(dmct_pkg::IDX_LOW_COUNT, 8'h05);
      report_and_stop;
   end
endmodule
`default_nettype wire
